// file: verilog/cite_pkg.sv
// Constants shared by the interrupt and trap-entry block
package cite_pkg;
  // ==========================================================
  // Register map (byte offsets on the AXI4-Lite bus)
  localparam int        AXI_AW      = 8;
  localparam logic [7:0] OFF_MSTATUS = 8'h00;
  localparam logic [7:0] OFF_MIE     = 8'h04;
  localparam logic [7:0] OFF_MIP     = 8'h08;
  localparam logic [7:0] OFF_MTVEC   = 8'h0c;
  localparam logic [7:0] OFF_MEPC    = 8'h10;
  localparam logic [7:0] OFF_MCAUSE  = 8'h14;
  localparam logic [7:0] OFF_CTRL    = 8'h18;
  localparam logic [7:0] OFF_LEVEL   = 8'h1c;
  // ==========================================================
  // Field positions
  localparam int MIE_BIT  = 3;
  localparam int MPIE_BIT = 7;
  localparam int DBG_BIT  = 0;
  // ==========================================================
  // Interrupt lines and causes
  localparam logic [31:0] LINE_MASK  = 32'hffff_0888;
  localparam logic [4:0]  LINE_SW    = 5'h03;
  localparam logic [4:0]  LINE_TIMER = 5'h07;
  localparam logic [4:0]  LINE_EXT   = 5'h0b;
  localparam int          CUSTOM_LO  = 16;
  localparam int          CUSTOM_HI  = 31;
  localparam logic [10:0] CAUSE_LOAD  = 11'h400;
  localparam logic [10:0] CAUSE_STORE = 11'h401;
  // ==========================================================
  // Vector table
  localparam logic [31:0] BASE_KEEP = 32'hffff_ff80;
  localparam logic [4:0]  NMI_SLOT  = 5'h0f;
  localparam logic [1:0]  MODE_CLIC = 2'h3;
  localparam logic [1:0]  PRIV_M    = 2'h3;
  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verilog/cite_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module cite_sync #(
  parameter int W = 32                // Lines carried
)(
  input  wire logic         aclk,     // Core clock
  input  wire logic         aresetn,  // Sync reset, low
  input  wire logic [W-1:0] d,        // Raw pin levels
  output logic      [W-1:0] q         // Synchronised levels
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [W-1:0] s1;                 // First stage, read by s2 only
    logic [W-1:0] s2;                 // Second stage
  } cite_sync_t;
  cite_sync_t s;
  cite_sync_t next_s;

  // Shift one stage
  always_comb
  begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  // Register the state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.s2;
endmodule // cite_sync

// file: verilog/cite_prio.sv
// Fixed-priority pick among enabled basic interrupt lines
`timescale 1ns/10ps
module cite_prio (
  input  wire logic [31:0] en,        // Pending and enabled
  output logic             any,       // Some line wins
  output logic      [4:0]  id         // Winning line
);
  // Line positions as indices
  localparam int LINE_TIMER_I = int'(cite_pkg::LINE_TIMER);
  localparam int LINE_SW_I    = int'(cite_pkg::LINE_SW);
  localparam int LINE_EXT_I   = int'(cite_pkg::LINE_EXT);

  // Weakest first, later hits override: timer, sw, ext, 16..31
  always_comb
  begin
    any = |en;
    id  = 5'h00;
    if (en[LINE_TIMER_I]) id = cite_pkg::LINE_TIMER;
    if (en[LINE_SW_I]) id = cite_pkg::LINE_SW;
    if (en[LINE_EXT_I]) id = cite_pkg::LINE_EXT;
    for (int i = cite_pkg::CUSTOM_LO; i <= cite_pkg::CUSTOM_HI; i++)
      if (en[i]) id = 5'(i);
  end
endmodule // cite_prio

// file: verilog/cite_core_irq.sv
// Interrupt and trap-entry unit with AXI4-Lite register access
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module cite_core_irq #(
  parameter bit advanced_irq_select = 1'b0, // CLIC option
  parameter int irq_index_width     = 5     // 1..10
)(
  input  wire logic        aclk,            // Core clock
  input  wire logic        aresetn,         // Sync reset, low
  input  wire logic [7:0]  awaddr,          // Write address
  input  wire logic        awvalid,         // Write address valid
  output logic             awready,         // Write address ready
  input  wire logic [31:0] wdata,           // Write data
  input  wire logic [3:0]  wstrb,           // Byte enables
  input  wire logic        wvalid,          // Write data valid
  output logic             wready,          // Write data ready
  output logic [1:0]       bresp,           // Write response
  output logic             bvalid,          // Write response valid
  input  wire logic        bready,          // Write response ready
  input  wire logic [7:0]  araddr,          // Read address
  input  wire logic        arvalid,         // Read address valid
  output logic             arready,         // Read address ready
  output logic [31:0]      rdata,           // Read data
  output logic [1:0]       rresp,           // Read response
  output logic             rvalid,          // Read data valid
  input  wire logic        rready,          // Read data ready
  input  wire logic [31:0] irq_lines,       // Basic lines, async
  input  wire logic        ext_ctrl_pending,// External pick valid
  input  wire logic [irq_index_width-1:0] ext_ctrl_index, // Its index
  input  wire logic [7:0]  ext_ctrl_level,  // Its level
  input  wire logic [1:0]  ext_ctrl_priv,   // Its privilege
  input  wire logic        ext_ctrl_shv,    // Its hw vectoring
  input  wire logic        instr_boundary,  // Core at boundary
  input  wire logic [31:0] cur_pc,          // Pc at boundary
  input  wire logic        sync_exc,        // Exception at boundary
  input  wire logic [10:0] sync_exc_code,   // Exception code
  input  wire logic        mret_exec,       // MRET at boundary
  input  wire logic        data_rvalid,     // Data response valid
  input  wire logic        data_err,        // Data response error
  input  wire logic        data_is_store,   // Response is a store
  output logic             trap_redirect,   // Fetch redirect pulse
  output logic [31:0]      redirect_addr,   // Fetch target
  output logic             nmi_pending      // NMI waiting
);
  // ==========================================================
  // State
  typedef struct packed {
    logic        mie_g;   // Global enable
    logic        mpie;    // Previous enable
    logic [31:0] mie_r;   // Line enables
    logic [31:0] mtvec;   // Vector base and mode
    logic [31:0] mepc;    // Saved pc
    logic [31:0] mcause;  // Trap cause
    logic        dbg;     // Debug mode
    logic [7:0]  lvl;     // Running level
    logic [7:0]  mpil;    // Previous level
    logic        nmi_pend;// NMI latched
    logic        nmi_st;  // NMI from store
    logic        redir;   // Redirect pulse
    logic [31:0] raddr;   // Redirect target
    logic        aw_ok;   // Address held
    logic [7:0]  awa;     // Held address
    logic        w_ok;    // Data held
    logic [31:0] wd;      // Held data
    logic [3:0]  ws;      // Held strobes
    logic        bv;      // Response pending
    logic [1:0]  br;      // Write answer
    logic        rv;      // Read pending
    logic [31:0] rd;      // Read data
    logic [1:0]  rr;      // Read answer
  } cite_state_t;
  cite_state_t s;
  cite_state_t next_s;

  // ==========================================================
  // Line synchroniser and priority pick
  logic [31:0] lines;     // Synchronised lines
  logic [31:0] mip;       // Pending view
  logic        irq_any;   // Some line enabled
  logic [4:0]  irq_id;    // Winning line

  cite_sync #(.W(32)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (irq_lines),
    .q       (lines)
  );

  // Only valid lines show; CLIC option ignores them
  assign mip = advanced_irq_select ? 32'h0 : (lines & cite_pkg::LINE_MASK);

  cite_prio u_prio (
    .en  (mip & s.mie_r),
    .any (irq_any),
    .id  (irq_id)
  );

  // ==========================================================
  // Trap decisions
  logic        b_take;    // Basic irq ready
  logic        c_take;    // CLIC irq ready
  logic        take_nmi;  // NMI taken now
  logic        take_exc;  // Exception taken now
  logic        take_int;  // Irq taken now
  logic        fire;      // Any trap taken
  logic        do_mret;   // Return taken
  logic [31:0] base;      // Vector base

  assign base   = s.mtvec & cite_pkg::BASE_KEEP;
  assign b_take = !advanced_irq_select && s.mie_g && irq_any;
  assign c_take = advanced_irq_select && s.mie_g && ext_ctrl_pending
                  && ext_ctrl_priv == cite_pkg::PRIV_M
                  && ext_ctrl_level > s.lvl;
  // Boundary sampling; debug masks NMI and irq
  assign take_nmi = instr_boundary && s.nmi_pend && !s.dbg;
  assign take_exc = instr_boundary && !take_nmi && sync_exc;
  assign take_int = instr_boundary && !take_nmi && !sync_exc
                    && (b_take || c_take) && !s.dbg;
  assign fire     = take_nmi || take_exc || take_int;
  assign do_mret  = instr_boundary && mret_exec && !fire;

  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (b[i]) r[8*i +: 8] = n[8*i +: 8];
    return r;
  endfunction

  // Read view of a register
  function automatic logic [32:0] view(input cite_state_t c,
                                       input logic [31:0] p,
                                       input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    case (a)
      cite_pkg::OFF_MSTATUS:
        r = {1'b0, 32'(c.mie_g) << cite_pkg::MIE_BIT
                 | 32'(c.mpie) << cite_pkg::MPIE_BIT};
      cite_pkg::OFF_MIE:    r = {1'b0, c.mie_r};
      cite_pkg::OFF_MIP:    r = {1'b0, p};
      cite_pkg::OFF_MTVEC:  r = {1'b0, c.mtvec};
      cite_pkg::OFF_MEPC:   r = {1'b0, c.mepc};
      cite_pkg::OFF_MCAUSE: r = {1'b0, c.mcause};
      cite_pkg::OFF_CTRL:   r = {1'b0, 32'(c.dbg) << cite_pkg::DBG_BIT};
      cite_pkg::OFF_LEVEL:  r = {1'b0, 24'h0, c.lvl};
      default:              r = {1'b1, 32'h0};   // Unmapped
    endcase
    return r;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    logic [31:0] m;       // Merged write word
    logic [32:0] v;       // Read view
    m      = 32'h0;
    v      = 33'h0;
    next_s = s;
    next_s.redir = 1'b0;
    // Write channels, taken in either order
    if (awvalid && !s.aw_ok)
    begin
      next_s.aw_ok = 1'b1;
      next_s.awa   = awaddr;
    end
    if (wvalid && !s.w_ok)
    begin
      next_s.w_ok = 1'b1;
      next_s.wd   = wdata;
      next_s.ws   = wstrb;
    end
    if (s.bv && bready)
      next_s.bv = 1'b0;
    // Perform write once both are held
    if (s.aw_ok && s.w_ok && !s.bv)
    begin
      v = view(s, mip, s.awa);
      m = merge(v[31:0], s.wd, s.ws);
      next_s.aw_ok = 1'b0;
      next_s.w_ok  = 1'b0;
      next_s.bv    = 1'b1;
      next_s.br    = v[32] ? cite_pkg::RESP_SLVERR : cite_pkg::RESP_OKAY;
      case (s.awa)
        cite_pkg::OFF_MSTATUS:
        begin
          next_s.mie_g = m[cite_pkg::MIE_BIT];
          next_s.mpie  = m[cite_pkg::MPIE_BIT];
        end
        cite_pkg::OFF_MIE:  next_s.mie_r = m & cite_pkg::LINE_MASK;
        cite_pkg::OFF_MTVEC:
          if (advanced_irq_select)
            next_s.mtvec = {m[31:2], cite_pkg::MODE_CLIC};
          else
            next_s.mtvec = {m[31:2], 1'b0, m[0]};
        cite_pkg::OFF_MEPC: next_s.mepc = {m[31:1], 1'b0};
        cite_pkg::OFF_CTRL: next_s.dbg  = m[cite_pkg::DBG_BIT];
        default: ;                                  // Read-only or unmapped
      endcase
    end
    // Read channel
    if (arvalid && !s.rv)
    begin
      v = view(s, mip, araddr);
      next_s.rv = 1'b1;
      next_s.rd = v[31:0];
      next_s.rr = v[32] ? cite_pkg::RESP_SLVERR : cite_pkg::RESP_OKAY;
    end
    else if (s.rv && rready)
      next_s.rv = 1'b0;
    // Trap entry overrides a same-cycle software write
    if (fire)
    begin
      next_s.mepc  = cur_pc;
      next_s.mpie  = s.mie_g;
      next_s.mie_g = 1'b0;
      next_s.redir = 1'b1;
      if (take_nmi)
      begin
        next_s.nmi_pend = 1'b0;
        next_s.mcause = {1'b1, 7'h0, s.lvl, 5'h0,
                         s.nmi_st ? cite_pkg::CAUSE_STORE
                                  : cite_pkg::CAUSE_LOAD};
        next_s.raddr = base | {25'h0, cite_pkg::NMI_SLOT, 2'h0};
      end
      else if (take_exc)
      begin
        next_s.mcause = {1'b0, 7'h0, s.lvl, 5'h0, sync_exc_code};
        next_s.raddr  = base;
      end
      else if (advanced_irq_select)
      begin
        next_s.mpil   = s.lvl;
        next_s.lvl    = ext_ctrl_level;
        next_s.mcause = {1'b1, 7'h0, s.lvl, 5'h0,
                         11'(ext_ctrl_index)};
        next_s.raddr  = ext_ctrl_shv
                        ? base + (32'(ext_ctrl_index) << 2) : base;
      end
      else
      begin
        next_s.mcause = {1'b1, 7'h0, s.lvl, 5'h0, 6'h0, irq_id};
        next_s.raddr  = s.mtvec[0]
                        ? base + (32'(irq_id) << 2) : base;
      end
    end
    else if (do_mret)
    begin
      next_s.mie_g = s.mpie;
      next_s.mpie  = 1'b1;
      next_s.lvl   = advanced_irq_select ? s.mpil : s.lvl;
      next_s.redir = 1'b1;
      next_s.raddr = s.mepc;
    end
    // First fault latched; set wins over entry clear
    if (data_rvalid && data_err && (!s.nmi_pend || take_nmi))
    begin
      next_s.nmi_pend = 1'b1;
      next_s.nmi_st   = data_is_store;
    end
  end

  // Register the state; all maskable irqs off at reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.mtvec <= advanced_irq_select ? 32'(cite_pkg::MODE_CLIC) : 32'h0;
    end
    else
      s <= next_s;
  end

  // ==========================================================
  // Outputs
  assign awready       = !s.aw_ok;
  assign wready        = !s.w_ok;
  assign bvalid        = s.bv;
  assign bresp         = s.br;
  assign arready       = !s.rv;
  assign rvalid        = s.rv;
  assign rdata         = s.rd;
  assign rresp         = s.rr;
  assign trap_redirect = s.redir;
  assign redirect_addr = s.raddr;
  assign nmi_pending   = s.nmi_pend;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_save;
    fire |=> s.mepc == $past(cur_pc) && s.mpie == $past(s.mie_g);
  endproperty
  a_save: assert property (p_save) else $error("entry context not saved");

  property p_exc;
    take_exc |=> trap_redirect && redirect_addr == $past(base);
  endproperty
  a_exc: assert property (p_exc) else $error("exception not at base");

  property p_bvec;
    take_int && !advanced_irq_select && s.mtvec[0]
      |=> redirect_addr == $past(base) + {25'h0, $past(irq_id), 2'h0};
  endproperty
  a_bvec: assert property (p_bvec) else $error("bad vectored target");

  property p_mret;
    do_mret |=> s.mie_g == $past(s.mpie) && redirect_addr == $past(s.mepc);
  endproperty
  a_mret: assert property (p_mret) else $error("return mismatch");

  property p_gate;
    instr_boundary && !s.mie_g && !s.nmi_pend && !sync_exc && !mret_exec
      |=> !trap_redirect;
  endproperty
  a_gate: assert property (p_gate) else $error("masked irq taken");

  property p_dbg;
    s.dbg && instr_boundary && !sync_exc && !mret_exec |=> !trap_redirect;
  endproperty
  a_dbg: assert property (p_dbg) else $error("irq in debug mode");

  property p_cause;
    take_int && !advanced_irq_select
      |=> s.mcause[31] && s.mcause[4:0] == $past(irq_id);
  endproperty
  a_cause: assert property (p_cause) else $error("bad irq cause");

  property p_nmi;
    take_nmi |=> redirect_addr == ($past(base) | 32'h0000_003c)
      && s.mcause[10:0] == ($past(s.nmi_st) ? 11'h401 : 11'h400) && !s.mie_g;
  endproperty
  a_nmi: assert property (p_nmi) else $error("bad NMI entry");

  property p_redir;
    fire |=> trap_redirect ##1 (trap_redirect == $past(fire || do_mret));
  endproperty
  a_redir: assert property (p_redir) else $error("redirect not one cycle");

  property p_latch;
    nmi_pending && !take_nmi |=> nmi_pending && $stable(s.nmi_st);
  endproperty
  a_latch: assert property (p_latch) else $error("later fault kept");

  property p_pre;
    take_int && advanced_irq_select
      |=> s.lvl == $past(ext_ctrl_level) && s.lvl > s.mpil;
  endproperty
  a_pre: assert property (p_pre) else $error("bad preemption");

  c_nmi:  cover property (take_nmi);
  c_bvec: cover property (take_int && s.mtvec[0]);
  c_ret:  cover property (fire ##[1:40] do_mret);
endmodule // cite_core_irq

// file: dv/cite_src.sv
// Behavioural interrupt sources on the far side of the trap-entry block
`timescale 1ns/10ps
module cite_src #(
  parameter int IW = 5                   // Width of the external index
)(
  input  wire logic          aclk,       // Core clock
  input  wire logic          aresetn,    // Sync reset, low
  input  wire logic [31:0]   raise,      // One-cycle request per line
  input  wire logic [31:0]   done,       // Handler completion per line
  output logic      [31:0]   irq_lines,  // Level requests
  output logic               ext_ctrl_pending, // Unused in basic build
  output logic      [IW-1:0] ext_ctrl_index,   // Unused in basic build
  output logic      [7:0]    ext_ctrl_level,   // Unused in basic build
  output logic      [1:0]    ext_ctrl_priv,    // Unused in basic build
  output logic               ext_ctrl_shv      // Unused in basic build
);
  // ==========================================================
  // Line holding
  // A line stays high until its handler reports completion
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_lines <= 32'h0000_0000;
    else
      irq_lines <= (irq_lines | raise) & ~done & cite_pkg::LINE_MASK;
  end
  // Controller-side inputs held low in the basic build
  assign ext_ctrl_pending = 1'b0;
  assign ext_ctrl_index   = '0;
  assign ext_ctrl_level   = 8'h00;
  // Privilege pinned to machine, the only level served
  assign ext_ctrl_priv    = cite_pkg::PRIV_M;
  assign ext_ctrl_shv     = 1'b0;
endmodule // cite_src

// file: dv/core_interrupt_trap_entry_tb.sv
// Self-checking bench for the interrupt and trap-entry unit
`timescale 1ns/10ps
module core_interrupt_trap_entry_tb;
  // ==========================================================
  // Signals
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0, cur_pc = 32'h0, raise = 32'h0, done = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic instr_boundary = 0, sync_exc = 0, mret_exec = 0;
  logic data_rvalid = 0, data_err = 0, data_is_store = 0;
  logic [10:0] sync_exc_code = 11'h000;
  wire awready, wready, bvalid, arready, rvalid, trap_redirect, nmi_pending;
  wire ext_ctrl_pending, ext_ctrl_shv;
  wire [1:0] bresp, rresp, ext_ctrl_priv;
  wire [4:0] ext_ctrl_index;
  wire [7:0] ext_ctrl_level;
  wire [31:0] rdata, redirect_addr, irq_lines;
  int n_errors = 0, comparisons = 0;
  logic [31:0] rd, ad;
  logic [1:0] rsp;
  logic tk;
  // Clock of 5 ns
  always #2.5 aclk = ~aclk;
  cite_core_irq uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .irq_lines, .ext_ctrl_pending, .ext_ctrl_index,
    .ext_ctrl_level, .ext_ctrl_priv, .ext_ctrl_shv, .instr_boundary, .cur_pc,
    .sync_exc, .sync_exc_code, .mret_exec, .data_rvalid, .data_err, .data_is_store,
    .trap_redirect, .redirect_addr, .nmi_pending);
  cite_src #(.IW(5)) src (.aclk, .aresetn, .raise, .done, .irq_lines, .ext_ctrl_pending,
    .ext_ctrl_index, .ext_ctrl_level, .ext_ctrl_priv, .ext_ctrl_shv);
  // ==========================================================
  // Helpers
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    bit ta, tw;
    ta = 0;
    tw = 0;
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge aclk);
      if (!ta && awready) begin ta = 1; awvalid <= 0; end
      if (!tw && wready) begin tw = 1; wvalid <= 0; end
      if (bvalid) begin rsp = bresp; bready <= 0; break; end
    end
    if (k == 20) begin n_errors++; tally_and_finish(); end
    else @(posedge aclk);
  endtask
  // Bus read into rd and rsp
  task automatic rdw(input logic [7:0] a);
    int k;
    araddr <= a; arvalid <= 1; rready <= 1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin rd = rdata; rsp = rresp; rready <= 0; break; end
    end
    if (k == 20) begin n_errors++; tally_and_finish(); end
    else @(posedge aclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdw(a);
    chk(rd, e);
  endtask
  // One boundary; watch a short span for the redirect
  task automatic trap(input logic x, input logic m, input logic et, input logic [31:0] ea);
    instr_boundary <= 1; sync_exc <= x; mret_exec <= m;
    @(posedge aclk);
    instr_boundary <= 0; sync_exc <= 0; mret_exec <= 0; tk = 0; ad = 0;
    repeat (3)
    begin
      @(posedge aclk);
      if (trap_redirect && !tk) begin tk = 1; ad = redirect_addr; end
    end
    chk({31'h0, tk}, {31'h0, et});
    if (et) chk(ad, ea);
  endtask
  // Source raise and completion, plus synchroniser delay
  task automatic fire(input logic [31:0] m, input logic up);
    if (up) raise <= m; else done <= m;
    @(posedge aclk);
    raise <= 0; done <= 0;
    repeat (4) @(posedge aclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_reset;
    rchk(cite_pkg::OFF_MSTATUS, 32'h0);
    rchk(cite_pkg::OFF_MIE, 32'h0);
    rdw(8'h20);
    chk(rd, 32'h0);
    chk({30'h0, rsp}, {30'h0, cite_pkg::RESP_SLVERR});
    wr(8'h20, 32'hffff_ffff);
    chk({30'h0, rsp}, {30'h0, cite_pkg::RESP_SLVERR});
  endtask
  task automatic s_exc;
    wr(cite_pkg::OFF_MTVEC, 32'h0000_0101);
    chk({30'h0, rsp}, {30'h0, cite_pkg::RESP_OKAY});
    rchk(cite_pkg::OFF_MTVEC, 32'h0000_0101);
    chk({30'h0, rsp}, {30'h0, cite_pkg::RESP_OKAY});
    cur_pc <= 32'h0000_2468; sync_exc_code <= 11'h00b;
    trap(1, 0, 1, 32'h100);
    rchk(cite_pkg::OFF_MEPC, 32'h2468);
    rchk(cite_pkg::OFF_MCAUSE, 32'h0000_000b);
    trap(0, 1, 1, 32'h2468);
  endtask
  task automatic s_mask_dbg;
    fire(32'h800, 1);
    trap(0, 0, 0, 32'h0);
    wr(cite_pkg::OFF_MIE, 32'h0001_0888);
    trap(0, 0, 0, 32'h0);
    wr(cite_pkg::OFF_CTRL, 32'h1);
    wr(cite_pkg::OFF_MSTATUS, 32'h8);
    trap(0, 0, 0, 32'h0);
    wr(cite_pkg::OFF_CTRL, 32'h0);
    trap(0, 0, 1, 32'h12c);
    rchk(cite_pkg::OFF_MSTATUS, 32'h80);
    rchk(cite_pkg::OFF_MCAUSE, 32'h8000_000b);
    fire(32'h800, 0);
    trap(0, 1, 1, 32'h2468);
    rchk(cite_pkg::OFF_MSTATUS, 32'h88);
  endtask
  task automatic s_prio;
    int ids[4];
    ids = '{16, 11, 3, 7};
    fire(32'h0001_0888, 1);
    rchk(cite_pkg::OFF_MIP, 32'h0001_0888);
    foreach (ids[i])
    begin
      trap(0, 0, 1, 32'h100 + 32'(4 * ids[i]));
      rchk(cite_pkg::OFF_MCAUSE, 32'h8000_0000 | 32'(ids[i]));
      fire(32'h1 << ids[i], 0);
      trap(0, 1, 1, 32'h2468);
    end
    // Non-vectored table: every line lands on the base
    wr(cite_pkg::OFF_MTVEC, 32'h0000_0180);
    fire(32'h80, 1);
    trap(0, 0, 1, 32'h180);
    rchk(cite_pkg::OFF_MCAUSE, 32'h8000_0007);
    fire(32'h80, 0);
    trap(0, 1, 1, 32'h2468);
  endtask
  task automatic s_nmi;
    data_rvalid <= 1; data_err <= 1; data_is_store <= 0;
    @(posedge aclk);
    data_rvalid <= 0; data_err <= 0;
    @(posedge aclk);
    data_rvalid <= 1; data_err <= 1; data_is_store <= 1;
    @(posedge aclk);
    data_rvalid <= 0; data_err <= 0; data_is_store <= 0;
    @(posedge aclk);
    chk({31'h0, nmi_pending}, 32'h1);
    trap(0, 0, 1, 32'h1bc);
    rchk(cite_pkg::OFF_MCAUSE, 32'h8000_0400);
    rchk(cite_pkg::OFF_MSTATUS, 32'h80);
    chk({31'h0, nmi_pending}, 32'h0);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    s_reset();
    s_exc();
    s_mask_dbg();
    s_prio();
    s_nmi();
    tally_and_finish();
  end
endmodule // core_interrupt_trap_entry_tb
